// >>> common/cbcd_pkg.sv
package cbcd_pkg;
   // ************************************************
   // sizes
   // ************************************************
   localparam int          CBCD_STACK_DEPTH = 4;
   localparam int          CBCD_SP_W        = 2;
   localparam logic [11:0] CBCD_PC_RESET    = 12'h000;

   // ************************************************
   // opcodes and opcode-map columns
   // ************************************************
   localparam logic [7:0] OP_NO_OPERATION  = 8'h05;
   localparam logic [7:0] OP_INTERRUPT_EXIT = 8'h4D;
   localparam logic [7:0] OP_SUBROUTINE_EXIT = 8'hCD;
   localparam logic [7:0] OP_STOP          = 8'h6D;
   localparam logic [7:0] OP_WAIT          = 8'hED;
   localparam logic [3:0] COL_CALL         = 4'h1;
   localparam logic [3:0] COL_BIT_TEST     = 4'h3;
   localparam logic [3:0] COL_INHERENT     = 4'h5;
   localparam logic [3:0] COL_INDIRECT     = 4'h7;
   localparam logic [3:0] COL_BIT_FORCE    = 4'hB;

   // ************************************************
   // branch offsets and cycle counts
   // ************************************************
   localparam logic [11:0] REL_SHORT_BIAS  = 12'h001;
   localparam logic [11:0] REL_LONG_BIAS   = 12'h002;
   localparam logic [11:0] CALL_RETURN_STEP = 12'h002;
   localparam logic [2:0]  CYC_BRANCH      = 3'h2;
   localparam logic [2:0]  CYC_BIT_TEST    = 3'h5;
   localparam logic [2:0]  CYC_BIT_FORCE   = 3'h4;
   localparam logic [2:0]  CYC_CONTROL     = 3'h2;
   localparam logic [2:0]  CYC_CALL        = 3'h4;
   localparam logic [2:0]  CYC_FOREIGN     = 3'h4;
   localparam logic [2:0]  CYC_ILLEGAL     = 3'h2;

   // ************************************************
   // types
   // ************************************************
   typedef enum logic [2:0] {
      CL_BRANCH   = 3'b000,
      CL_CALL     = 3'b001,
      CL_BIT_TEST = 3'b010,
      CL_BIT_FORCE = 3'b011,
      CL_CONTROL  = 3'b100,
      CL_FOREIGN  = 3'b101,
      CL_ILLEGAL  = 3'b110
   } cbcd_class_t;

   typedef enum logic {
      ST_RUN  = 1'b0,
      ST_HALT = 1'b1
   } cbcd_state_t;
endpackage

// >>> src/cbcd_core.sv
`timescale 1ns/1ps
// Operation
// - four one-byte branches on carry/zero set or clear, 2 cycles, flags kept
// - short branch displacement is 5-bit signed, reach -15 to +16
// - three-byte bit-test branch, 5 cycles, on bit clear or bit set
// - bit test copies tested bit into carry always, zero kept
// - bit-test branch displacement is 8-bit signed, reach -126 to +129
// - bit number is a 3-bit field inside the opcode
// - bit force high/low on any data byte, 2 bytes, 4 cycles, flags kept
// - no-operation, exits, stop, wait: 1 byte, 2 cycles, only interrupt exit changes flags
// - with watchdog selected, stop acts as wait
// - call uses 12-bit absolute target, 2 bytes, 4 cycles, flags kept
// - low nibbles 0,2,4,6 decode as nonzero, no-carry, zero, carry branches
// - low nibble 1 decodes as subroutine call in every row
// - low nibble 3 is bit test; even rows clear, odd set; rows pick bit
// - column 5 row 0 is no-operation, odd rows are index ops, other even rows illegal
// - bit test: byte 3 displacement, byte 2 data address, opcode bit and sense
// - branch target is the displacement added to the branch's own address plus 1 (short) or plus 2 (bit test)
module cbcd_core
   import cbcd_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   output logic [11:0]      prog_addr_out,
   input  wire logic [7:0]  prog_data_in,
   output logic [7:0]       data_addr_out,
   input  wire logic [7:0]  data_rd_in,
   output logic             data_wr_en_out,
   output logic [7:0]       data_wr_out,
   input  wire logic        watchdog_sel_in,
   input  wire logic        wake_in,
   input  wire logic        irq_carry_in,
   input  wire logic        irq_zero_in,
   input  wire logic [1:0]  foreign_len_in,
   input  wire logic        foreign_flag_we_in,
   input  wire logic        foreign_carry_in,
   input  wire logic        foreign_zero_in,
   output logic             foreign_start_out,
   output logic [7:0]       opcode_out,
   output logic [11:0]      pc_out,
   output logic             carry_out,
   output logic             zero_out,
   output logic             stop_out,
   output logic             wait_out,
   output logic             illegal_out
);

   // ************************************************
   // state
   // ************************************************
   cbcd_state_t  state;
   logic [2:0]   phase;
   logic [11:0]  pc;
   logic [7:0]   op;
   logic [7:0]   byte2;
   logic [7:0]   byte3;
   logic         carry;
   logic         zero;
   logic [11:0]  stack_mem [CBCD_STACK_DEPTH];
   logic [CBCD_SP_W-1:0] sp;

   // ************************************************
   // decode
   // ************************************************
   wire [3:0] lo_nib = op[3:0];
   wire [3:0] hi_nib = op[7:4];
   // columns 8..F of the branch rows reuse op[3] as a displacement bit
   wire is_branch  = ~op[0];
   wire is_call    = (lo_nib == COL_CALL);
   wire is_btest   = (lo_nib == COL_BIT_TEST);
   wire is_bforce  = (lo_nib == COL_BIT_FORCE);
   wire is_ctrl    = (op == OP_NO_OPERATION) | (op == OP_SUBROUTINE_EXIT) | (op == OP_INTERRUPT_EXIT)
                   | (op == OP_STOP) | (op == OP_WAIT);
   // even rows of column 5 except row 0 hold no instruction
   wire ill_col5   = (lo_nib == COL_INHERENT) & ~hi_nib[0] & (hi_nib != 4'h0);
   wire ill_col7   = (lo_nib == COL_INDIRECT) & ((hi_nib == 4'h7) | (hi_nib == 4'h9) | (hi_nib == 4'hF));
   wire cbcd_class_t cls = is_branch ? CL_BRANCH :
                           is_call   ? CL_CALL :
                           is_btest  ? CL_BIT_TEST :
                           is_bforce ? CL_BIT_FORCE :
                           is_ctrl   ? CL_CONTROL :
                           (ill_col5 | ill_col7) ? CL_ILLEGAL : CL_FOREIGN;
   wire [2:0] cyc_len = (cls == CL_BRANCH)    ? CYC_BRANCH :
                        (cls == CL_CALL)      ? CYC_CALL :
                        (cls == CL_BIT_TEST)  ? CYC_BIT_TEST :
                        (cls == CL_BIT_FORCE) ? CYC_BIT_FORCE :
                        (cls == CL_CONTROL)   ? CYC_CONTROL :
                        (cls == CL_FOREIGN)   ? CYC_FOREIGN : CYC_ILLEGAL;
   wire last = (state == ST_RUN) & (phase != 3'h0) & (phase == cyc_len - 3'h1);

   // ************************************************
   // branch conditions and targets
   // ************************************************
   // op[2:1]: 00 nonzero, 01 no carry, 10 zero, 11 carry
   wire cond_true = op[1] ? (op[2] ? carry : ~carry) : (op[2] ? zero : ~zero);
   wire [11:0] disp5    = {{7{op[7]}}, op[7:3]};
   wire [11:0] short_tg = pc + disp5 + REL_SHORT_BIAS;
   wire [11:0] disp8    = {{4{byte3[7]}}, byte3};
   wire [11:0] long_tg  = pc + disp8 + REL_LONG_BIAS;
   wire [2:0]  bit_num  = {op[5], op[6], op[7]};
   wire        bit_sense = op[4];
   wire        tested_bit = data_rd_in[bit_num];
   wire [7:0]  bit_mask = 8'h01 << bit_num;
   wire [7:0]  forced   = bit_sense ? (data_rd_in | bit_mask) : (data_rd_in & ~bit_mask);
   wire [11:0] call_tg  = {hi_nib, byte2};
   wire [11:0] return_addr = pc + CALL_RETURN_STEP;
   wire [CBCD_SP_W-1:0] sp_dec = sp - 1'b1;
   wire is_stop_op = (op == OP_STOP);
   // stop is suppressed when the watchdog is in use
   wire do_stop = is_stop_op & ~watchdog_sel_in;
   wire do_wait = (op == OP_WAIT) | (is_stop_op & watchdog_sel_in);

   // ************************************************
   // next program counter at the end of an instruction
   // ************************************************
   logic [11:0] next_pc;
   always_comb
   begin
      next_pc = pc + 12'h001;
      case (cls)
         CL_BRANCH    : next_pc = cond_true ? short_tg : pc + 12'h001;
         CL_CALL      : next_pc = call_tg;
         CL_BIT_TEST  : next_pc = (tested_bit == bit_sense) ? long_tg : pc + 12'h003;
         CL_BIT_FORCE : next_pc = pc + 12'h002;
         CL_CONTROL   : next_pc = (op == OP_SUBROUTINE_EXIT) | (op == OP_INTERRUPT_EXIT)
                                  ? stack_mem[sp_dec] : pc + 12'h001;
         CL_FOREIGN   : next_pc = pc + {10'h000, foreign_len_in};
         default      : next_pc = pc + 12'h001;
      endcase
   end

   // ************************************************
   // sequencer and operand fetch
   // ************************************************
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         state         <= ST_RUN;
         phase         <= 3'h0;
         pc            <= CBCD_PC_RESET;
         prog_addr_out <= CBCD_PC_RESET;
         op            <= 8'h00;
         byte2         <= 8'h00;
         byte3         <= 8'h00;
      end
      else if (state == ST_HALT)
      begin
         if (wake_in)
            state <= ST_RUN;
      end
      else
      begin
         if (phase == 3'h0)
            op <= prog_data_in;
         if (phase == 3'h1)
            byte2 <= prog_data_in;
         if (phase == 3'h2)
            byte3 <= prog_data_in;
         if (last)
         begin
            phase         <= 3'h0;
            pc            <= next_pc;
            prog_addr_out <= next_pc;
            if ((cls == CL_CONTROL) & (do_stop | do_wait))
               state <= ST_HALT;
         end
         else
         begin
            phase         <= phase + 3'h1;
            prog_addr_out <= pc + 12'(phase + 3'h1);
         end
      end
   end

   // ************************************************
   // flags; only bit test, interrupt exit and foreign ops write them
   // ************************************************
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         carry <= 1'b0;
         zero  <= 1'b0;
      end
      else if ((state == ST_RUN) & (cls == CL_BIT_TEST) & (phase == 3'h3))
         carry <= tested_bit;
      else if (last & (cls == CL_CONTROL) & (op == OP_INTERRUPT_EXIT))
      begin
         carry <= irq_carry_in;
         zero  <= irq_zero_in;
      end
      else if ((state == ST_RUN) & (phase != 3'h0) & (cls == CL_FOREIGN) & foreign_flag_we_in)
      begin
         carry <= foreign_carry_in;
         zero  <= foreign_zero_in;
      end
   end

   // ************************************************
   // return stack; overflow wraps silently, no trap
   // ************************************************
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
         sp <= '0;
      else if (last & (cls == CL_CALL))
      begin
         stack_mem[sp] <= return_addr;
         sp            <= sp + 1'b1;
      end
      else if (last & (cls == CL_CONTROL) & ((op == OP_SUBROUTINE_EXIT) | (op == OP_INTERRUPT_EXIT)))
         sp <= sp_dec;
   end

   // ************************************************
   // data space access and pulses
   // ************************************************
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         data_addr_out     <= 8'h00;
         data_wr_en_out    <= 1'b0;
         data_wr_out       <= 8'h00;
         foreign_start_out <= 1'b0;
         stop_out          <= 1'b0;
         wait_out          <= 1'b0;
         illegal_out       <= 1'b0;
      end
      else
      begin
         if ((state == ST_RUN) & (phase == 3'h2))
            data_addr_out <= byte2;
         // read-modify-write lands one cycle after the read
         data_wr_en_out    <= (state == ST_RUN) & (cls == CL_BIT_FORCE) & (phase == 3'h3);
         if ((state == ST_RUN) & (cls == CL_BIT_FORCE) & (phase == 3'h3))
            data_wr_out <= forced;
         foreign_start_out <= (state == ST_RUN) & (phase == 3'h1) & (cls == CL_FOREIGN);
         stop_out          <= last & (cls == CL_CONTROL) & do_stop;
         wait_out          <= last & (cls == CL_CONTROL) & do_wait;
         illegal_out       <= last & (cls == CL_ILLEGAL);
      end
   end

   assign opcode_out = op;
   assign pc_out     = pc;
   assign carry_out  = carry;
   assign zero_out   = zero;

   // ************************************************
   // checks
   // ************************************************
   a_branch_flags_kept: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state == ST_RUN) & (phase == 3'h1) & (cls == CL_BRANCH) |=> (phase == 3'h0) & $stable(carry) & $stable(zero))
      else $error("branch took wrong length or touched flags");
   a_branch_target: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      last & (cls == CL_BRANCH) & cond_true |=> pc == $past(pc) + $past(disp5) + 12'h001)
      else $error("taken short branch landed wrong");
   a_btest_length: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state == ST_RUN) & (phase == 3'h1) & (cls == CL_BIT_TEST) |-> ##3 last ##1 (phase == 3'h0))
      else $error("bit test branch not five cycles");
   a_btest_carry: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state == ST_RUN) & (phase == 3'h3) & (cls == CL_BIT_TEST)
      |=> (carry == $past(data_rd_in[bit_num])) & $stable(zero))
      else $error("tested bit not copied to carry");
   a_bforce_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state == ST_RUN) & (phase == 3'h3) & (cls == CL_BIT_FORCE)
      |=> data_wr_en_out & (data_wr_out[$past(bit_num)] == $past(bit_sense)) & $stable(carry))
      else $error("bit force wrote wrong value");
   a_call_push: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      last & (cls == CL_CALL)
      |=> (pc == {$past(hi_nib), $past(byte2)}) & (stack_mem[sp_dec] == $past(pc) + 12'h002))
      else $error("call target or return address wrong");
   a_stop_as_wait: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      last & is_stop_op & watchdog_sel_in |=> wait_out & ~stop_out & (state == ST_HALT))
      else $error("stop not replaced by wait");
   a_illegal_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      last & (cls == CL_ILLEGAL) |=> illegal_out & (pc == $past(pc) + 12'h001) & $stable(carry) & $stable(zero))
      else $error("illegal opcode disturbed state");
   a_ctrl_flags: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state == ST_RUN) & (phase == 3'h1) & (cls == CL_CONTROL) & (op != OP_INTERRUPT_EXIT)
      |=> (phase == 3'h0) & $stable(carry) & $stable(zero))
      else $error("control op length or flags wrong");

endmodule // cbcd_core

// >>> src/cbcd_unused_placeholder_removed.sv
`timescale 1ns/1ps

// >>> test/cbcd_core_tb.sv
`timescale 1ns/1ps
module cbcd_core_tb;
   import cbcd_pkg::*;
   // ************************************************
   // clock, stimulus and memories
   // ************************************************
   logic        core_clk_in;
   logic        rst_n_in;
   logic        watchdog_sel_in;
   logic        wake_in;
   logic        irq_carry_in;
   logic        irq_zero_in;
   logic [11:0] prog_addr_out;
   logic [7:0]  data_addr_out;
   logic        data_wr_en_out;
   logic [7:0]  data_wr_out;
   logic [11:0] pc_out;
   logic        carry_out;
   logic        zero_out;
   logic        stop_out;
   logic        wait_out;
   logic        illegal_out;
   logic [1:0]  foreign_len_in;
   logic        foreign_start_out;
   logic [7:0]  opcode_out;
   logic [7:0]  rom [0:4095];
   logic [7:0]  ram [0:255];
   int          num_errors;
   int          tests_run;

   // both memories answer in the same cycle, as the core expects
   wire [7:0] prog_data_w = rom[prog_addr_out];
   wire [7:0] data_rd_w   = ram[data_addr_out];

   cbcd_core dut (
      .core_clk_in        (core_clk_in),
      .rst_n_in           (rst_n_in),
      .prog_addr_out      (prog_addr_out),
      .prog_data_in       (prog_data_w),
      .data_addr_out      (data_addr_out),
      .data_rd_in         (data_rd_w),
      .data_wr_en_out     (data_wr_en_out),
      .data_wr_out        (data_wr_out),
      .watchdog_sel_in    (watchdog_sel_in),
      .wake_in            (wake_in),
      .irq_carry_in       (irq_carry_in),
      .irq_zero_in        (irq_zero_in),
      .foreign_len_in     (foreign_len_in),
      .foreign_flag_we_in (1'b0),
      .foreign_carry_in   (1'b0),
      .foreign_zero_in    (1'b0),
      .foreign_start_out  (foreign_start_out),
      .opcode_out         (opcode_out),
      .pc_out             (pc_out),
      .carry_out          (carry_out),
      .zero_out           (zero_out),
      .stop_out           (stop_out),
      .wait_out           (wait_out),
      .illegal_out        (illegal_out)
   );

   initial
   begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end

   // ************************************************
   // shared tasks
   // ************************************************
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // illegal filler so a stray fetch is deterministic, then a 16-cycle reset
   task automatic boot(input logic wd);
      foreach (rom[i]) rom[i] = 8'h25;
      rst_n_in = 1'b0;
      watchdog_sel_in = wd;
      repeat (16) @(negedge core_clk_in);
      chk(pc_out, 12'h000);
      chk(12'({carry_out, zero_out, stop_out, wait_out, illegal_out, data_wr_en_out}), 12'h000);
      rst_n_in = 1'b1;
   endtask

   // pc must hold for n-1 cycles and land on exp at the n-th
   task automatic step(input int n, input logic [11:0] exp);
      logic [11:0] start;
      start = pc_out;
      for (int i = 1; i < n; i++)
      begin
         @(negedge core_clk_in);
         chk(pc_out, start);
      end
      @(negedge core_clk_in);
      chk(pc_out, exp);
   endtask

   task automatic end_sim;
      if (num_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_short_branch;
      boot(1'b0);
      rom[0] = 8'h30; rom[7] = 8'h34; rom[8] = 8'h36; rom[9] = 8'h32; rom[16] = 8'hF0;
      step(2, 12'h007);
      step(2, 12'h008);
      step(2, 12'h009);
      step(2, 12'h010);
      step(2, 12'h00F);
      chk(12'({carry_out, zero_out}), 12'h000);
   endtask

   task automatic t_bit_test;
      boot(1'b0);
      ram[8'h40] = 8'h01; ram[8'h41] = 8'hFE; ram[8'h42] = 8'h10;
      rom[0] = 8'h13; rom[1] = 8'h40; rom[2] = 8'h10;
      rom[18] = 8'h36;
      rom[25] = 8'h13; rom[26] = 8'h41; rom[27] = 8'h80;
      rom[28] = 8'h03; rom[29] = 8'h41; rom[30] = 8'h80;
      rom[12'hF9E] = 8'h23; rom[12'hF9F] = 8'h42; rom[12'hFA0] = 8'h05;
      step(5, 12'h012);
      chk(12'(carry_out), 12'h001);
      step(2, 12'h019);
      step(5, 12'h01C);
      chk(12'(data_addr_out), 12'h041);
      chk(12'(carry_out), 12'h000);
      step(5, 12'hF9E);
      step(5, 12'hFA1);
      chk(12'({carry_out, zero_out}), 12'h002);
   endtask

   // plain ram bytes only: port data registers are never the target
   task automatic t_bit_force;
      boot(1'b0);
      ram[8'h50] = 8'hFF; ram[8'h51] = 8'h00;
      rom[0] = 8'h6B; rom[1] = 8'h50; rom[2] = 8'h7B; rom[3] = 8'h51;
      step(4, 12'h002);
      chk(12'({data_wr_en_out, data_wr_out}), 12'h1BF);
      chk(12'(data_addr_out), 12'h050);
      step(4, 12'h004);
      chk(12'({data_wr_en_out, data_wr_out}), 12'h140);
      chk(12'({carry_out, zero_out}), 12'h000);
   endtask

   task automatic t_call;
      boot(1'b0);
      irq_carry_in = 1'b1;
      irq_zero_in = 1'b1;
      rom[0] = 8'h51; rom[1] = 8'h23; rom[12'h523] = OP_SUBROUTINE_EXIT;
      rom[2] = 8'h71; rom[3] = 8'h00; rom[12'h700] = OP_INTERRUPT_EXIT;
      rom[4] = 8'h25; rom[5] = 8'h34; rom[12] = 8'hC2;
      // row 1 of column 5 is an index op, run by the outside datapath
      rom[13] = OP_NO_OPERATION; rom[14] = 8'h15;
      step(4, 12'h523);
      step(2, 12'h002);
      chk(12'({carry_out, zero_out}), 12'h000);
      step(4, 12'h700);
      step(2, 12'h004);
      chk(12'({carry_out, zero_out}), 12'h003);
      step(2, 12'h005);
      chk(12'(illegal_out), 12'h001);
      step(2, 12'h00C);
      step(2, 12'h00D);
      chk(12'({carry_out, zero_out}), 12'h003);
      step(2, 12'h00E);
      chk(12'(opcode_out), 12'(OP_NO_OPERATION));
      @(negedge core_clk_in);
      chk(12'(opcode_out), 12'h015);
      @(negedge core_clk_in);
      chk(12'(foreign_start_out), 12'h001);
      // foreign length input is one byte, so the index op moves pc by one
      step(2, 12'h00F);
      chk(12'({carry_out, zero_out}), 12'h003);
   endtask

   task automatic t_stop(input logic wd);
      logic [11:0] held;
      boot(wd);
      rom[0] = OP_STOP;
      repeat (2) @(negedge core_clk_in);
      chk(12'({stop_out, wait_out}), {10'h000, ~wd, wd});
      held = pc_out;
      repeat (4) @(negedge core_clk_in);
      chk(pc_out, held);
      chk(12'({stop_out, wait_out}), 12'h000);
      wake_in = 1'b1;
      @(negedge core_clk_in);
      wake_in = 1'b0;
   endtask

   // ************************************************
   // main sequence and watchdog
   // ************************************************
   initial
   begin
      num_errors = 0;
      tests_run = 0;
      rst_n_in = 1'b0;
      watchdog_sel_in = 1'b0;
      wake_in = 1'b0;
      irq_carry_in = 1'b0;
      irq_zero_in = 1'b0;
      foreign_len_in = 2'h1;
      foreach (ram[i]) ram[i] = 8'h00;
      @(negedge core_clk_in);
      t_short_branch();
      t_bit_test();
      t_bit_force();
      t_call();
      t_stop(1'b0);
      t_stop(1'b1);
      end_sim();
   end

   // whole run is under 200 cycles; the 3000-cycle limit means a hang
   initial
   begin
      #(25 * 3000);
      num_errors++;
      end_sim();
   end
endmodule // cbcd_core_tb
